// File: core/stap_params.svh
// constants for the scan test port: instruction codes, scan lengths, id fields
// assumes inclusion from the scan test port module and its bench only
`ifndef STAP_PARAMS_SVH
`define STAP_PARAMS_SVH
`define STAP_IR_W 3
`define STAP_IR_EXTEST 3'h0
`define STAP_IR_IDCODE 3'h1
`define STAP_IR_SAMPZ 3'h2
`define STAP_IR_SAMPLE 3'h4
`define STAP_IR_BYPASS 3'h7
`define STAP_IR_CAPT 2'h1
`define STAP_ID_W 32
`define STAP_BSR_LEN 109
`define STAP_OE_CELL 108
`define STAP_Q_W 36
`define STAP_Q_LSB 0
`define STAP_OE_RESET 1'h0
`define STAP_BYP_CAPT 1'h0
`define STAP_ID_REV 3'h0
// part and maker fields: arbitrary neutral values
`define STAP_ID_PART 17'h0A5A5
`define STAP_ID_MAKER 11'h2B3
`define STAP_ID_MARK 1'h1
`endif

// File: core/stap_pkg.sv
// types for the scan test port
// assumes nothing beyond a SystemVerilog compiler
package stap_pkg;
    typedef enum logic [3:0] {
        ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
        ST_PAU_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR,
        ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
    } stap_state_t;
endpackage : stap_pkg

// File: core/stap_tap.sv
// scan test port of the memory: tap controller, instruction, bypass, id
// and boundary registers on the test clock; output bus control on I_CLK.
// assumes the tester makes I_TCK and drives I_TMS/I_TDI from it; I_PINS
// are the memory pins, async to I_TCK; I_CORE_* come from I_CLK logic.
//
// Operation
// - id instruction captures a fixed 32-bit code and shifts it out
// - instruction register holds id after power up and in test-logic-reset
// - high-z sample puts the boundary register on the serial path
// - high-z sample floats the read bus until the next update-ir or test-logic-reset
// - sample/preload snapshots all pins into the boundary register at capture
// - after capture, shift-dr shifts captured values out
// - preload sets the latched boundary outputs before another test
// - captured data shifts out while new preload data shifts in
// - bypass puts the single bypass bit on the serial path
// - external test drives preloaded values onto the output pins
// - external test puts the boundary register on the serial path
// - cell 108, latched, controls the read bus under external test
// - control cell high drives the bus, low floats it
// - update-dr copies every shift cell into its latch
// - control latch resets low at power up and in test-logic-reset
// - controller moves on the select level at each rising test clock
// - codes: ext 000, id 001, high-z sample 010, sample 100, bypass 111
// - capture-ir loads 01 into the two low instruction bits
// - select high for five rising edges resets the controller
// - inputs sampled on rising edges, serial output on falling edges
`timescale 1ns/100ps
`include "stap_params.svh"

module stap_tap #(
    parameter int BSR_LEN = `STAP_BSR_LEN,
    parameter int OE_CELL = `STAP_OE_CELL,
    parameter int Q_W = `STAP_Q_W,
    parameter int Q_LSB = `STAP_Q_LSB
) (
    input wire logic I_CLK,
    input wire logic I_RST_B,
    input wire logic I_CE,
    input wire logic I_TCK,
    input wire logic I_TMS,
    input wire logic I_TDI,
    output logic O_TDO,
    output logic O_TDO_OE,
    input wire logic [OE_CELL-1:0] I_PINS,
    input wire logic [Q_W-1:0] I_CORE_Q,
    input wire logic I_CORE_OE,
    output logic [Q_W-1:0] O_Q,
    output logic O_Q_OE
);
    localparam int IW = `STAP_IR_W;
    localparam logic [`STAP_ID_W-1:0] ID_CODE =
        {`STAP_ID_REV, `STAP_ID_PART, `STAP_ID_MAKER, `STAP_ID_MARK};

    generate
        if (OE_CELL != BSR_LEN - 1 || Q_LSB + Q_W > OE_CELL || Q_W < 1) begin : g_bad
            $error("stap_tap: boundary layout cannot hold the output bus");
        end
    endgenerate

    // test clock reset: power-up reset brought over, plus the pins
    logic rst_m1;
    logic rst_m2;
    logic [OE_CELL-1:0] pins_m1;
    logic [OE_CELL-1:0] pins_m2;

    always_ff @(posedge I_TCK) begin
        rst_m1 <= I_RST_B;
        rst_m2 <= rst_m1;
        pins_m1 <= I_PINS;
        pins_m2 <= pins_m1;
    end

    logic tck_rst;
    assign tck_rst = ~rst_m2;

    // controller
    stap_pkg::stap_state_t state_r;
    stap_pkg::stap_state_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            stap_pkg::ST_TLR: state_nxt = I_TMS ? stap_pkg::ST_TLR : stap_pkg::ST_RTI;
            stap_pkg::ST_RTI: state_nxt = I_TMS ? stap_pkg::ST_SEL_DR : stap_pkg::ST_RTI;
            stap_pkg::ST_SEL_DR: state_nxt = I_TMS ? stap_pkg::ST_SEL_IR : stap_pkg::ST_CAP_DR;
            stap_pkg::ST_CAP_DR: state_nxt = I_TMS ? stap_pkg::ST_EX1_DR : stap_pkg::ST_SH_DR;
            stap_pkg::ST_SH_DR: state_nxt = I_TMS ? stap_pkg::ST_EX1_DR : stap_pkg::ST_SH_DR;
            stap_pkg::ST_EX1_DR: state_nxt = I_TMS ? stap_pkg::ST_UPD_DR : stap_pkg::ST_PAU_DR;
            stap_pkg::ST_PAU_DR: state_nxt = I_TMS ? stap_pkg::ST_EX2_DR : stap_pkg::ST_PAU_DR;
            stap_pkg::ST_EX2_DR: state_nxt = I_TMS ? stap_pkg::ST_UPD_DR : stap_pkg::ST_SH_DR;
            stap_pkg::ST_UPD_DR: state_nxt = I_TMS ? stap_pkg::ST_SEL_DR : stap_pkg::ST_RTI;
            stap_pkg::ST_SEL_IR: state_nxt = I_TMS ? stap_pkg::ST_TLR : stap_pkg::ST_CAP_IR;
            stap_pkg::ST_CAP_IR: state_nxt = I_TMS ? stap_pkg::ST_EX1_IR : stap_pkg::ST_SH_IR;
            stap_pkg::ST_SH_IR: state_nxt = I_TMS ? stap_pkg::ST_EX1_IR : stap_pkg::ST_SH_IR;
            stap_pkg::ST_EX1_IR: state_nxt = I_TMS ? stap_pkg::ST_UPD_IR : stap_pkg::ST_PAU_IR;
            stap_pkg::ST_PAU_IR: state_nxt = I_TMS ? stap_pkg::ST_EX2_IR : stap_pkg::ST_PAU_IR;
            stap_pkg::ST_EX2_IR: state_nxt = I_TMS ? stap_pkg::ST_UPD_IR : stap_pkg::ST_SH_IR;
            stap_pkg::ST_UPD_IR: state_nxt = I_TMS ? stap_pkg::ST_SEL_DR : stap_pkg::ST_RTI;
        endcase
    end

    // scan registers
    logic [IW-1:0] ir_sh_r;
    logic [IW-1:0] ir_sh_nxt;
    logic [IW-1:0] ir_r;
    logic [IW-1:0] ir_nxt;
    logic byp_r;
    logic byp_nxt;
    logic [`STAP_ID_W-1:0] id_sh_r;
    logic [`STAP_ID_W-1:0] id_sh_nxt;
    logic [BSR_LEN-1:0] bsr_sh_r;
    logic [BSR_LEN-1:0] bsr_sh_nxt;
    logic [BSR_LEN-1:0] bsr_upd_r;
    logic [BSR_LEN-1:0] bsr_upd_nxt;
    logic bsr_sel;
    logic id_sel;

    // reserved codes fall back to bypass, the harmless path
    assign bsr_sel = ir_r == `STAP_IR_EXTEST || ir_r == `STAP_IR_SAMPZ
        || ir_r == `STAP_IR_SAMPLE;
    assign id_sel = ir_r == `STAP_IR_IDCODE;

    always_comb begin
        ir_sh_nxt = ir_sh_r;
        ir_nxt = ir_r;
        byp_nxt = byp_r;
        id_sh_nxt = id_sh_r;
        bsr_sh_nxt = bsr_sh_r;
        bsr_upd_nxt = bsr_upd_r;
        if (state_r == stap_pkg::ST_TLR) begin
            ir_nxt = `STAP_IR_IDCODE;
            bsr_upd_nxt[OE_CELL] = `STAP_OE_RESET;
        end else if (state_r == stap_pkg::ST_CAP_IR) begin
            ir_sh_nxt = {{(IW-2){1'b0}}, `STAP_IR_CAPT};
        end else if (state_r == stap_pkg::ST_SH_IR) begin
            ir_sh_nxt = {I_TDI, ir_sh_r[IW-1:1]};
        end else if (state_r == stap_pkg::ST_UPD_IR) begin
            ir_nxt = ir_sh_r;
        end else if (state_r == stap_pkg::ST_CAP_DR) begin
            if (bsr_sel) begin
                // control cell keeps its latch; pins cells take a snapshot
                bsr_sh_nxt = {bsr_upd_r[OE_CELL], pins_m2};
            end else if (id_sel) begin
                id_sh_nxt = ID_CODE;
            end else begin
                byp_nxt = `STAP_BYP_CAPT;
            end
        end else if (state_r == stap_pkg::ST_SH_DR) begin
            // one pass moves captured bits out and preload bits in
            if (bsr_sel) begin
                bsr_sh_nxt = {I_TDI, bsr_sh_r[BSR_LEN-1:1]};
            end else if (id_sel) begin
                id_sh_nxt = {I_TDI, id_sh_r[`STAP_ID_W-1:1]};
            end else begin
                byp_nxt = I_TDI;
            end
        end else if (state_r == stap_pkg::ST_UPD_DR && bsr_sel) begin
            bsr_upd_nxt = bsr_sh_r;
        end
    end

    // handover of output control to I_CLK: toggle one edge after the change
    logic upd_seen_r;
    logic upd_seen_nxt;
    logic tog_r;
    logic tog_nxt;

    assign upd_seen_nxt = state_r == stap_pkg::ST_UPD_IR
        || state_r == stap_pkg::ST_UPD_DR || state_r == stap_pkg::ST_TLR;
    assign tog_nxt = tog_r ^ upd_seen_r;

    always_ff @(posedge I_TCK) begin
        if (tck_rst) begin
            state_r <= stap_pkg::ST_TLR;
            ir_sh_r <= `STAP_IR_IDCODE;
            ir_r <= `STAP_IR_IDCODE;
            byp_r <= `STAP_BYP_CAPT;
            id_sh_r <= '0;
            bsr_sh_r <= '0;
            bsr_upd_r <= '0;
            upd_seen_r <= 1'b0;
            tog_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ir_sh_r <= ir_sh_nxt;
            ir_r <= ir_nxt;
            byp_r <= byp_nxt;
            id_sh_r <= id_sh_nxt;
            bsr_sh_r <= bsr_sh_nxt;
            bsr_upd_r <= bsr_upd_nxt;
            upd_seen_r <= upd_seen_nxt;
            tog_r <= tog_nxt;
        end
    end

    // serial output changes on the falling edge
    logic tdo_nxt;
    logic tdo_oe_nxt;

    always_comb begin
        tdo_oe_nxt = state_r == stap_pkg::ST_SH_IR || state_r == stap_pkg::ST_SH_DR;
        if (state_r == stap_pkg::ST_SH_IR) begin
            tdo_nxt = ir_sh_r[0];
        end else if (bsr_sel) begin
            tdo_nxt = bsr_sh_r[0];
        end else if (id_sel) begin
            tdo_nxt = id_sh_r[0];
        end else begin
            tdo_nxt = byp_r;
        end
    end

    always_ff @(negedge I_TCK) begin
        if (tck_rst) begin
            O_TDO <= 1'b0;
            O_TDO_OE <= 1'b0;
        end else begin
            O_TDO <= tdo_nxt;
            O_TDO_OE <= tdo_oe_nxt;
        end
    end

    // system clock side
    logic t_m1;
    logic t_m2;
    logic t_m3;
    logic ext_r;
    logic ext_nxt;
    logic sz_r;
    logic sz_nxt;
    logic oe_r;
    logic oe_nxt;
    logic [Q_W-1:0] pre_r;
    logic [Q_W-1:0] pre_nxt;
    logic [Q_W-1:0] q_nxt;
    logic q_oe_nxt;
    logic take;

    assign take = t_m2 ^ t_m3;

    always_comb begin
        ext_nxt = ext_r;
        sz_nxt = sz_r;
        oe_nxt = oe_r;
        pre_nxt = pre_r;
        // bundle is stable for several test clocks around the toggle
        if (take) begin
            ext_nxt = ir_r == `STAP_IR_EXTEST;
            sz_nxt = ir_r == `STAP_IR_SAMPZ;
            oe_nxt = bsr_upd_r[OE_CELL];
            pre_nxt = bsr_upd_r[Q_LSB +: Q_W];
        end
        if (sz_r) begin
            q_oe_nxt = 1'b0;
        end else if (ext_r) begin
            q_oe_nxt = oe_r;
        end else begin
            q_oe_nxt = I_CORE_OE;
        end
        q_nxt = ext_r ? pre_r : I_CORE_Q;
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            t_m1 <= 1'b0;
            t_m2 <= 1'b0;
            t_m3 <= 1'b0;
            ext_r <= 1'b0;
            sz_r <= 1'b0;
            oe_r <= `STAP_OE_RESET;
            pre_r <= '0;
            O_Q <= '0;
            O_Q_OE <= 1'b0;
        end else if (I_CE) begin
            t_m1 <= tog_r;
            t_m2 <= t_m1;
            t_m3 <= t_m2;
            ext_r <= ext_nxt;
            sz_r <= sz_nxt;
            oe_r <= oe_nxt;
            pre_r <= pre_nxt;
            O_Q <= q_nxt;
            O_Q_OE <= q_oe_nxt;
        end
    end

    // checks
    sequence tms_five_s;
        I_TMS [*5];
    endsequence

    sequence cap_dr_bsr_s;
        state_r == stap_pkg::ST_CAP_DR && bsr_sel;
    endsequence

    tms_reset_a: assert property (@(posedge I_TCK) disable iff (tck_rst)
        tms_five_s |=> state_r == stap_pkg::ST_TLR)
        else $error("five high select edges did not reset the controller");

    tlr_idcode_a: assert property (@(posedge I_TCK) disable iff (tck_rst)
        state_r == stap_pkg::ST_TLR |=> ir_r == `STAP_IR_IDCODE)
        else $error("instruction not id after test-logic-reset");

    capir_pattern_a: assert property (@(posedge I_TCK) disable iff (tck_rst)
        state_r == stap_pkg::ST_CAP_IR |=> ir_sh_r[1:0] == `STAP_IR_CAPT)
        else $error("capture-ir pattern wrong");

    idcode_cap_a: assert property (@(posedge I_TCK) disable iff (tck_rst)
        state_r == stap_pkg::ST_CAP_DR && id_sel |=> id_sh_r == ID_CODE)
        else $error("id code not captured");

    pins_cap_a: assert property (@(posedge I_TCK) disable iff (tck_rst)
        cap_dr_bsr_s |=> bsr_sh_r[OE_CELL-1:0] == $past(pins_m2))
        else $error("pin snapshot not captured");

    upd_latch_a: assert property (@(posedge I_TCK) disable iff (tck_rst)
        state_r == stap_pkg::ST_UPD_DR && bsr_sel |=> bsr_upd_r == $past(bsr_sh_r))
        else $error("update-dr did not latch the shift stage");

    oe_preset_a: assert property (@(posedge I_TCK) disable iff (tck_rst)
        state_r == stap_pkg::ST_TLR |=> !bsr_upd_r[OE_CELL])
        else $error("control latch not preset low");

    bypass_shift_a: assert property (@(posedge I_TCK) disable iff (tck_rst)
        state_r == stap_pkg::ST_SH_DR && !bsr_sel && !id_sel |=> byp_r == $past(I_TDI))
        else $error("bypass bit did not take the serial input");

    samplez_float_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        sz_r && I_CE |=> !O_Q_OE)
        else $error("read bus driven under high-z sample");

    extest_drive_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        ext_r && !sz_r && I_CE |=> O_Q_OE == $past(oe_r) && O_Q == $past(pre_r))
        else $error("external test bus does not follow the latches");
endmodule : stap_tap

// File: sim/stap_tester.sv
// model of the external test controller: free-running test clock, walks the tap
// assumes the port samples tms/tdi on rising edges and moves tdo on falling edges
`timescale 1ns/100ps

module stap_tester (
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    input wire logic i_tdo
);
    initial begin
        o_tck = 1'h0;
        o_tms = 1'h1;
        o_tdi = 1'h1;
        forever #32 o_tck = ~o_tck;
    end

    // drive just after the falling edge, sample tdo at the rising edge
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        @(negedge o_tck);
        o_tms = tms;
        o_tdi = tdi;
        @(posedge o_tck);
        tdo = i_tdo;
    endtask : step

    task automatic reset5();
        logic d;
        for (int i = 0; i < 5; i++) step(1'h1, 1'h1, d);
        step(1'h0, 1'h1, d);
    endtask : reset5

    // from run-test-idle back to run-test-idle; callers never pass reserved codes
    task automatic ir(input logic [2:0] code, output logic [2:0] cap);
        logic d;
        step(1'h1, 1'h1, d);
        step(1'h1, 1'h1, d);
        step(1'h0, 1'h1, d);
        step(1'h0, 1'h1, d);
        for (int i = 0; i < 3; i++) step(i == 2, code[i], cap[i]);
        step(1'h1, 1'h1, d);
        step(1'h0, 1'h1, d);
    endtask : ir

    // new data shifts in while captured data shifts out
    task automatic dr(input logic [127:0] din, output logic [127:0] dout);
        logic d;
        step(1'h1, 1'h1, d);
        step(1'h0, 1'h1, d);
        step(1'h0, 1'h1, d);
        for (int i = 0; i < 128; i++) step(i == 127, din[i], dout[i]);
        step(1'h1, 1'h1, d);
        step(1'h0, 1'h1, d);
    endtask : dr
endmodule : stap_tester

// File: sim/tb_top.sv
// self-checking bench for the scan test port
// assumes pins and core data stay still while a scan runs, no clock cells there
`timescale 1ns/100ps
`include "stap_params.svh"

module tb_top;
    localparam logic [31:0] ID_EXP = {`STAP_ID_REV, `STAP_ID_PART, `STAP_ID_MAKER,
        `STAP_ID_MARK};
    // legal codes only, reserved ones never loaded
    localparam logic [26:0] SEQ = {3'h0, 3'h7, 3'h1, 3'h4, 3'h7, 3'h2, 3'h1, 3'h0, 3'h4};
    logic clk, rst_b, tck, tms, tdi, tdo, q_oe, core_oe, d, ce, tdo_oe;
    logic [107:0] pins;
    logic [35:0] core_q, q;
    logic [108:0] latch_exp;
    logic [127:0] din, dout;
    logic [2:0] cap, c;
    logic [31:0] rnd;
    int error_cnt, checks, oe_cnt, oe_base;

    stap_tap DUT (
        .I_CLK(clk), .I_RST_B(rst_b), .I_CE(ce),
        .I_TCK(tck), .I_TMS(tms), .I_TDI(tdi),
        .O_TDO(tdo), .O_TDO_OE(tdo_oe),
        .I_PINS(pins), .I_CORE_Q(core_q), .I_CORE_OE(core_oe),
        .O_Q(q), .O_Q_OE(q_oe)
    );

    stap_tester u_tst (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo));

    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    // shift cycles seen with the serial output driven
    always @(posedge tck) begin
        if (tdo_oe === 1'h1) oe_cnt++;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic int path_len(input logic [2:0] code);
        if (code == 3'h0 || code == 3'h2 || code == 3'h4) return 109;
        if (code == 3'h1) return 32;
        return 1;
    endfunction : path_len

    task automatic chk(input string name, input logic [127:0] exp, input logic [127:0] got);
        checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            error_cnt++;
        end
    endtask : chk

    task automatic new_rand();
        @(negedge clk);
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            din = {din[111:0], rnd[15:0]};
        end
        pins = din[127:20] ^ {4{rnd[26:0]}}; // still pins, no moving clock cells
        core_q = {rnd[3:0], rnd};
        core_oe = rnd[9];
    endtask : new_rand

    // output bus crosses into the system clock; frozen while the enable is low
    task automatic check_out(input logic [2:0] code);
        logic [36:0] held;
        @(negedge clk);
        held = {q_oe, q};
        ce = 1'h0;
        repeat (6) @(negedge clk);
        chk("frozen bus", held, {q_oe, q});
        ce = 1'h1;
        repeat (8) @(negedge clk);
        if (code == 3'h0) begin
            chk("bus data", latch_exp[35:0], q);
            chk("bus enable", latch_exp[108], q_oe);
        end else if (code == 3'h2) begin
            chk("bus enable", 1'h0, q_oe);
        end else begin
            chk("bus data", core_q, q);
            chk("bus enable", core_oe, q_oe);
        end
    endtask : check_out

    task automatic check_path(input logic [2:0] code);
        int n;
        n = path_len(code);
        if (code == 3'h1) chk("id code", ID_EXP, dout[31:0]);
        if (n == 1) chk("bypass bit", 1'h0, dout[0]);
        if (n == 109) chk("pin capture", pins, dout[107:0]);
        if (n == 109) chk("bus control cell", latch_exp[108], dout[108]);
        chk("serial path", din << n, (dout >> n) << n);
    endtask : check_path

    task automatic report_and_stop();
        if (error_cnt == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop

    initial begin
        error_cnt = 0;
        checks = 0;
        rnd = 32'h58;
        rst_b = 1'h0;
        pins = '0;
        core_q = '0;
        core_oe = 1'h0;
        din = '0;
        latch_exp = '0;
        ce = 1'h1;
        oe_cnt = 0;
        oe_base = 0;
        repeat (16) @(negedge clk);
        rst_b = 1'h1;
        repeat (6) @(posedge tck);
        u_tst.step(1'h0, 1'h1, d);
        new_rand();
        u_tst.dr(din, dout);
        check_path(3'h1);
        for (int k = 0; k < 9; k++) begin
            c = SEQ[3*k +: 3];
            new_rand();
            // control cell set on the first and last pass, so the final preset is seen
            din[127] = (k == 0 || k == 8);
            oe_base = oe_cnt;
            u_tst.ir(c, cap);
            chk("ir capture", 2'h1, cap[1:0]);
            chk("tdo enable count", 8'h03, oe_cnt - oe_base);
            check_out(c);
            oe_base = oe_cnt;
            u_tst.dr(din, dout);
            chk("tdo enable count", 8'h80, oe_cnt - oe_base);
            check_path(c);
            if (path_len(c) == 109) latch_exp = din[127:19];
            check_out(c);
        end
        u_tst.reset5();
        new_rand();
        u_tst.dr(din, dout);
        check_path(3'h1);
        u_tst.ir(3'h0, cap);
        repeat (8) @(negedge clk);
        chk("bus enable", 1'h0, q_oe);
        report_and_stop();
    end

    // whole run is about 1.8k test clocks
    initial begin
        #3000000;
        error_cnt++;
        report_and_stop();
    end
endmodule : tb_top
